// *** logic/fld_mode_ctrl.sv ***
// LED flash driver mode, flash sequencing and current control
// Function
// - SCL low timeout while active forces shutdown
// - Standby, zero current, when nothing enabled
// - Torch and assist use seven low bits
// - Indicator: six bits, PWM at 31.25 kHz
// - Strobe off: flash starts on output enable
// - Strobe edge starts flash, timeout ends it
// - Strobe level flash, capped by timeout
// - Transmit mask pin lowers flash current
// - Pre-flash supply check: fault, block or reduce
// - Supply sag steps current down per 8 us
// - Actual current readable during flash
// - Minimum current held after the flash
// - Fault register read clears all faults
// - Level strobe held past timeout: stop, fault
// - SCL high in shutdown releases reset at once

`include "fld_map.svh"

module fld_mode_ctrl #(
    parameter int SCL_LOW_CYC = `FLD_SCL_LOW_CYC,
    parameter int FLASH_STEP_CYC = `FLD_FLASH_STEP_CYC,
    parameter int SD_W = 22,
    parameter int FT_W = 24
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Pins from outside the clock domain
    input wire logic i_scl,
    input wire logic i_strobe,
    input wire logic i_torch,
    input wire logic i_vin_below_low_v,
    input wire logic i_vin_below_run,
    // Configuration fields
    input wire logic [1:0] i_mode,
    input wire logic i_out_on,
    input wire logic [1:0] i_ext_torch,
    input wire logic i_strobe_on,
    input wire logic i_strobe_type,
    input wire logic i_vin_low_v_shutdown,
    input wire logic [3:0] i_ind_pwm,
    input wire logic [7:0] i_flash_timeout,
    // Current settings
    input wire logic [7:0] i_led_current,
    input wire logic [7:0] i_sink_current_setting_b,
    input wire logic [7:0] i_txmask_current,
    // Fault register read strobe
    input wire logic i_fault_read,
    // Sink currents
    output logic [7:0] o_sink_current_a,
    output logic [7:0] o_sink_current_b,
    // Readback currents
    output logic [7:0] o_current_actual,
    output logic [7:0] o_current_min,
    // Fault flags
    output logic o_fault_uvlo,
    output logic o_fault_timeout,
    output logic o_fault_txmask,
    // Status and control back to the register file
    output fld_pkg::fld_mode_t o_mode,
    output logic o_shutdown,
    output logic o_reg_reset,
    output logic o_ctrl_clear
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [4:0] pin_level;
    logic [4:0] pin_rise;
    wire scl_s = pin_level[0];
    wire strobe_s = pin_level[1];
    wire strobe_rise = pin_rise[1];
    wire torch_s = pin_level[2];
    wire vlow_s = pin_level[3];
    wire vrun_s = pin_level[4];

    // All pins pass two flops before use
    fld_pin_sync #(.W(5)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_pin({i_vin_below_run, i_vin_below_low_v, i_torch, i_strobe,
                i_scl}),
        .o_level(pin_level),
        .o_rise(pin_rise)
    );

    ////////////////////////////////////////////////////////////////////
    // Serial clock low shutdown

    logic [SD_W-1:0] scl_low_cnt;
    logic shutdown;
    wire op_active = (i_mode != `FLD_MODE_STANDBY) && i_out_on && !shutdown;
    wire sd_hit = op_active && !scl_s
        && (scl_low_cnt == SD_W'(SCL_LOW_CYC - 1));

    // Count SCL low time only in active modes
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            scl_low_cnt <= '0;
            shutdown <= 1'b0;
        end else if (scl_s) begin
            scl_low_cnt <= '0;
            shutdown <= 1'b0;
        end else if (sd_hit) begin
            scl_low_cnt <= '0;
            shutdown <= 1'b1;
        end else if (op_active) begin
            scl_low_cnt <= scl_low_cnt + SD_W'(1);
        end else begin
            scl_low_cnt <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash trigger decode

    fld_pkg::fld_flash_t fstate;
    fld_pkg::fld_flash_t next_fstate;
    logic flash_sel_d;
    logic [FT_W-1:0] flash_cnt;
    wire flash_sel = (i_mode == `FLD_MODE_FLASH) && i_out_on && !shutdown;
    wire flash_sel_rise = flash_sel && !flash_sel_d;
    wire level_mode = i_strobe_on && i_strobe_type;
    wire trig = flash_sel && (i_strobe_on ? strobe_rise
        : flash_sel_rise);
    wire [FT_W-1:0] flash_limit =
        FT_W'(({1'b0, i_flash_timeout} + 9'h001) * FLASH_STEP_CYC);
    wire expire = (flash_cnt >= flash_limit - FT_W'(1));
    wire blocked = vlow_s && i_vin_low_v_shutdown;
    wire run_end = !flash_sel || expire || (level_mode && !strobe_s);
    wire done_end = i_strobe_on ? !(level_mode && strobe_s) : !flash_sel;

    // Flash sequencer next state
    always_comb begin
        next_fstate = fstate;
        unique case (fstate)
            fld_pkg::FLD_F_IDLE: begin
                if (trig) begin
                    next_fstate = fld_pkg::FLD_F_CHECK;
                end
            end
            fld_pkg::FLD_F_CHECK: begin
                if (blocked || !flash_sel) begin
                    next_fstate = fld_pkg::FLD_F_DONE;
                end else begin
                    next_fstate = fld_pkg::FLD_F_RUN;
                end
            end
            fld_pkg::FLD_F_RUN: begin
                if (run_end) begin
                    next_fstate = fld_pkg::FLD_F_DONE;
                end
            end
            fld_pkg::FLD_F_DONE: begin
                if (done_end) begin
                    next_fstate = fld_pkg::FLD_F_IDLE;
                end
            end
        endcase
    end

    // Sequencer state, trigger history and flash timer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || shutdown) begin
            fstate <= fld_pkg::FLD_F_IDLE;
            flash_sel_d <= 1'b0;
            flash_cnt <= '0;
        end else begin
            fstate <= next_fstate;
            flash_sel_d <= flash_sel;
            if (fstate == fld_pkg::FLD_F_RUN) begin
                flash_cnt <= flash_cnt + FT_W'(1);
            end else begin
                flash_cnt <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash current with supply reductions

    logic [7:0] step_cnt;
    logic use_txm;
    logic uv_hit;
    logic [7:0] cur_actual;
    logic [7:0] cur_min;
    wire in_run = (fstate == fld_pkg::FLD_F_RUN);
    wire in_check = (fstate == fld_pkg::FLD_F_CHECK);
    wire step_tick = (step_cnt == 8'(`FLD_STEP_CYC - 1));
    wire txm_active = (i_ext_torch == `FLD_EXT_TXMASK) && torch_s;
    wire [7:0] flash_target = (txm_active || use_txm) ? i_txmask_current
        : i_led_current;
    wire [7:0] check_target = vlow_s ? i_txmask_current
        : (txm_active ? i_txmask_current : i_led_current);

    // Step timer for 8 us per LSB
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !in_run || step_tick) begin
            step_cnt <= 8'h00;
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    // Current in use and lowest current of the pulse
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || shutdown) begin
            cur_actual <= `FLD_CUR_RESET;
            cur_min <= `FLD_CUR_RESET;
            use_txm <= 1'b0;
            uv_hit <= 1'b0;
        end else if (in_check) begin
            use_txm <= vlow_s;
            uv_hit <= 1'b0;
            cur_actual <= check_target;
            cur_min <= check_target;
        end else if (in_run) begin
            if (cur_actual > flash_target) begin
                cur_actual <= flash_target;
            end else if (step_tick && vrun_s && cur_actual != 8'h00) begin
                cur_actual <= cur_actual - 8'h01;
                uv_hit <= 1'b1;
            end else if (step_tick && !vrun_s && !uv_hit
                    && cur_actual < flash_target) begin
                cur_actual <= cur_actual + 8'h01;
            end
            if (cur_actual < cur_min) begin
                cur_min <= cur_actual;
            end
        end else if (cur_actual < cur_min) begin
            cur_min <= cur_actual;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault flags, set wins over the read clear

    wire uvlo_set = (in_check && vlow_s) || (in_run && vrun_s);
    wire tmo_set = in_run && expire && flash_sel
        && !(i_strobe_on && !i_strobe_type);
    wire tmo_stop = tmo_set && level_mode && strobe_s;
    wire txm_set = in_run && txm_active;

    // Sticky faults
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || shutdown) begin
            o_fault_uvlo <= 1'b0;
            o_fault_timeout <= 1'b0;
            o_fault_txmask <= 1'b0;
        end else begin
            o_fault_uvlo <= uvlo_set || (o_fault_uvlo && !i_fault_read);
            o_fault_timeout <= tmo_set
                || (o_fault_timeout && !i_fault_read);
            o_fault_txmask <= txm_set || (o_fault_txmask && !i_fault_read);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode decode and indicator PWM

    logic [9:0] pwm_cnt;
    wire pwm_wrap = (pwm_cnt == 10'(`FLD_PWM_CYC - 1));
    wire [9:0] pwm_on_len =
        10'(({1'b0, i_ind_pwm} + 5'h01) * (`FLD_PWM_CYC / `FLD_PWM_STEPS));
    wire pwm_on = (pwm_cnt < pwm_on_len);
    wire ext_on = (i_mode == `FLD_MODE_STANDBY)
        && (i_ext_torch == `FLD_EXT_TORCH) && torch_s;
    fld_pkg::fld_mode_t mode_now;

    // Free-running 31.25 kHz period counter
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || pwm_wrap) begin
            pwm_cnt <= 10'h000;
        end else begin
            pwm_cnt <= pwm_cnt + 10'h001;
        end
    end

    // Present operating mode
    assign mode_now = shutdown ? fld_pkg::FLD_SHUTDOWN
        : ext_on ? fld_pkg::FLD_EXT_TORCH
        : !i_out_on ? fld_pkg::FLD_STANDBY
        : (i_mode == `FLD_MODE_INDICATOR) ? fld_pkg::FLD_INDICATOR
        : (i_mode == `FLD_MODE_ASSIST) ? fld_pkg::FLD_ASSIST
        : (i_mode == `FLD_MODE_FLASH) ? fld_pkg::FLD_FLASH
        : fld_pkg::FLD_STANDBY;

    logic [7:0] next_cur_a;
    logic [7:0] next_cur_b;

    // Sink current per mode
    always_comb begin
        next_cur_a = 8'h00;
        next_cur_b = 8'h00;
        unique case (mode_now)
            fld_pkg::FLD_SHUTDOWN, fld_pkg::FLD_STANDBY: begin
                next_cur_a = 8'h00;
                next_cur_b = 8'h00;
            end
            fld_pkg::FLD_EXT_TORCH, fld_pkg::FLD_ASSIST: begin
                next_cur_a = {1'b0, i_led_current[6:0]};
                next_cur_b = {1'b0, i_sink_current_setting_b[6:0]};
            end
            fld_pkg::FLD_INDICATOR: begin
                if (pwm_on) begin
                    next_cur_a = {2'b00, i_led_current[5:0]};
                    next_cur_b = {2'b00, i_sink_current_setting_b[5:0]};
                end
            end
            fld_pkg::FLD_FLASH: begin
                if (in_run && !tmo_stop) begin
                    next_cur_a = cur_actual;
                    next_cur_b = cur_actual;
                end
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sink_current_a <= `FLD_CUR_RESET;
            o_sink_current_b <= `FLD_CUR_RESET;
            o_current_actual <= `FLD_CUR_RESET;
            o_current_min <= `FLD_CUR_RESET;
            o_mode <= fld_pkg::FLD_STANDBY;
            o_shutdown <= 1'b0;
            o_reg_reset <= 1'b0;
            o_ctrl_clear <= 1'b0;
        end else begin
            o_sink_current_a <= next_cur_a;
            o_sink_current_b <= next_cur_b;
            o_current_actual <= in_run ? cur_actual : 8'h00;
            o_current_min <= cur_min;
            o_mode <= mode_now;
            o_shutdown <= shutdown;
            o_reg_reset <= sd_hit;
            o_ctrl_clear <= tmo_stop;
        end
    end

endmodule : fld_mode_ctrl

// *** logic/fld_map.svh ***
// Constants for the LED flash driver mode and current control
`ifndef FLD_MAP_SVH
`define FLD_MAP_SVH

// Reference clock
`define FLD_CLK_HZ 25000000
// Indicator PWM rate and its cycle count
`define FLD_PWM_HZ 31250
`define FLD_PWM_CYC (`FLD_CLK_HZ / `FLD_PWM_HZ)
// Duty steps of the indicator PWM field
`define FLD_PWM_STEPS 16
// Low-voltage current step time, one LSB per step
`define FLD_STEP_NS 8000
`define FLD_STEP_CYC ((`FLD_STEP_NS * (`FLD_CLK_HZ / 1000000)) / 1000)
// Serial clock low time before shutdown
`define FLD_SCL_LOW_MS 100
`define FLD_SCL_LOW_CYC (`FLD_SCL_LOW_MS * (`FLD_CLK_HZ / 1000))
// Length of one flash timeout field step
`define FLD_FLASH_STEP_MS 2
`define FLD_FLASH_STEP_CYC (`FLD_FLASH_STEP_MS * (`FLD_CLK_HZ / 1000))
// Mode field codes
`define FLD_MODE_STANDBY 2'h0
`define FLD_MODE_INDICATOR 2'h1
`define FLD_MODE_ASSIST 2'h2
`define FLD_MODE_FLASH 2'h3
// External torch selection codes
`define FLD_EXT_TXMASK 2'h1
`define FLD_EXT_TORCH 2'h2
// Reset values
`define FLD_CUR_RESET 8'h00

`endif

// *** logic/fld_pkg.sv ***
// Types for the LED flash driver mode and current control
package fld_pkg;

    // Operating mode seen at the sinks
    typedef enum logic [2:0] {
        FLD_SHUTDOWN = 3'h0,
        FLD_STANDBY = 3'h1,
        FLD_EXT_TORCH = 3'h2,
        FLD_INDICATOR = 3'h3,
        FLD_ASSIST = 3'h4,
        FLD_FLASH = 3'h5
    } fld_mode_t;

    // Flash sequencer states
    typedef enum logic [1:0] {
        FLD_F_IDLE = 2'h0,
        FLD_F_CHECK = 2'h1,
        FLD_F_RUN = 2'h2,
        FLD_F_DONE = 2'h3
    } fld_flash_t;

endpackage : fld_pkg

// *** logic/fld_pin_sync.sv ***
// Two-flop pin synchroniser with rising edge detect
module fld_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Asynchronous pins
    input wire logic [W-1:0] i_pin,
    // Synchronised level and rising edge pulse
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise
);

    logic [W-1:0] meta;
    logic [W-1:0] prev;

    // Two stages, then one more for edge detect
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_level <= '0;
            prev <= '0;
        end else begin
            meta <= i_pin;
            o_level <= meta;
            prev <= o_level;
        end
    end

    // Rising edge from the second and third stage only
    assign o_rise = o_level & ~prev;

endmodule : fld_pin_sync

// *** testbench/fld_mode_ctrl_asserts.sv ***
// Assertion checker for the flash driver mode control
module fld_mode_ctrl_asserts #(
    parameter int SCL_LOW_CYC = 200,
    parameter int FLASH_STEP_CYC = 20
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Watched inputs
    input wire logic i_scl,
    input wire logic [7:0] i_flash_timeout,
    input wire logic i_fault_read,
    // Watched outputs
    input wire logic [7:0] o_sink_current_a,
    input wire logic [7:0] o_sink_current_b,
    input wire logic [7:0] o_current_actual,
    input wire logic o_fault_uvlo,
    input wire logic o_fault_timeout,
    input wire logic o_fault_txmask,
    input wire fld_pkg::fld_mode_t o_mode,
    input wire logic o_shutdown,
    input wire logic o_reg_reset,
    input wire logic o_ctrl_clear
);
    int low_cnt;
    int run_cnt;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////
    // Serial clock low time and flash run length
    always_ff @(posedge i_ref_clk) begin
        low_cnt <= (i_rst || i_scl) ? 0 : low_cnt + 1;
        run_cnt <= (i_rst || o_current_actual == 8'h00) ? 0 : run_cnt + 1;
    end
    ////////////////////////////////////////////////
    // Properties
    property p_idle_zero;
        o_mode == fld_pkg::FLD_STANDBY |-> o_sink_current_a == 8'h00
            && o_sink_current_b == 8'h00;
    endproperty
    property p_seven_bits;
        o_mode inside {fld_pkg::FLD_ASSIST, fld_pkg::FLD_EXT_TORCH}
            |-> !o_sink_current_a[7] && !o_sink_current_b[7];
    endproperty
    property p_six_bits;
        o_mode == fld_pkg::FLD_INDICATOR |-> o_sink_current_a[7:6] == 2'h0;
    endproperty
    property p_track;
        o_current_actual != 8'h00 && !o_ctrl_clear
            && o_mode == fld_pkg::FLD_FLASH
            |-> o_sink_current_a == o_current_actual
            && o_sink_current_b == o_sink_current_a;
    endproperty
    property p_sd_pulse;
        o_reg_reset |=> o_shutdown && !o_reg_reset;
    endproperty
    property p_sd_late;
        $rose(o_shutdown) |-> low_cnt >= SCL_LOW_CYC;
    endproperty
    property p_wake;
        o_shutdown && $rose(i_scl) |-> ##[1:6] !o_shutdown;
    endproperty
    property p_pin_cap;
        o_ctrl_clear |-> ##[0:2] o_fault_timeout;
    endproperty
    property p_read_clr;
        i_fault_read && o_mode == fld_pkg::FLD_STANDBY
            |=> !o_fault_uvlo && !o_fault_timeout && !o_fault_txmask;
    endproperty
    property p_run_cap;
        run_cnt <= (int'(i_flash_timeout) + 1) * FLASH_STEP_CYC;
    endproperty
    ////////////////////////////////////////////////
    // Assertions and covers
    a_idle_zero: assert property (p_idle_zero)
        else $error("sink current in standby");
    a_seven_bits: assert property (p_seven_bits)
        else $error("top bit used in torch or assist");
    a_six_bits: assert property (p_six_bits)
        else $error("indicator current above six bits");
    a_track: assert property (p_track)
        else $error("sinks differ from actual current");
    a_sd_pulse: assert property (p_sd_pulse)
        else $error("register reset pulse wrong");
    a_sd_late: assert property (p_sd_late)
        else $error("shutdown before clock low time");
    a_wake: assert property (p_wake)
        else $error("shutdown not left on clock high");
    a_pin_cap: assert property (p_pin_cap)
        else $error("control clear without timeout fault");
    a_read_clr: assert property (p_read_clr)
        else $error("faults kept after fault read");
    a_run_cap: assert property (p_run_cap)
        else $error("flash longer than timeout");
    c_reset: cover property (o_reg_reset);
    c_clear: cover property (o_ctrl_clear);
    c_txmask: cover property ($rose(o_fault_txmask));
endmodule : fld_mode_ctrl_asserts

bind fld_mode_ctrl fld_mode_ctrl_asserts #(
    .SCL_LOW_CYC(SCL_LOW_CYC), .FLASH_STEP_CYC(FLASH_STEP_CYC)
) u_chk (.i_ref_clk, .i_rst, .i_scl, .i_flash_timeout, .i_fault_read,
    .o_sink_current_a, .o_sink_current_b, .o_current_actual, .o_fault_uvlo,
    .o_fault_timeout, .o_fault_txmask, .o_mode, .o_shutdown, .o_reg_reset,
    .o_ctrl_clear);

// *** testbench/fld_host_model.sv ***
// Host model: serial clock source and current setting writes
module fld_host_model (
    // Bench controls
    input wire logic i_frame,
    input wire logic i_power_off,
    input wire logic [7:0] i_cur,
    // Lines towards the block
    output logic o_scl,
    output logic [7:0] o_cur_a,
    output logic [7:0] o_cur_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tgl = 1'b1;
    // Clock toggles only within frames, idles high between them
    initial begin
        #7;
        forever begin
            #160;
            tgl = i_frame ? !tgl : 1'b1;
        end
    end
    // Powered-off host pulls the clock low
    assign o_scl = i_power_off ? 1'b0 : tgl;
    // Both settings always written alike
    assign o_cur_a = i_cur;
    assign o_cur_b = i_cur;
endmodule : fld_host_model

// *** testbench/flash_led_mode_control_tb.sv ***
// Testbench for the flash driver mode control
module flash_led_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, stb = 0, trc = 0, vlo = 0, vrun = 0, on = 0;
    logic son = 0, sty = 0, lsd = 0, frd = 0, frame = 0, poff = 0;
    logic [1:0] mode = 0, ext = 0;
    logic [3:0] pwm = 0;
    logic [7:0] tmo = 2, cur = 8'hA5, txc = 8'h40, first, last;
    logic scl, uv, tf, txf, sd, rr, cc, ccs = 0, rrs = 0;
    logic [7:0] cur_a, cur_b, sa, sb, act, cmin;
    fld_pkg::fld_mode_t md;
    int bad_count = 0, total_checks = 0, cyc = 0, len, n;
    ////////////////////////////////////////////////
    fld_host_model u_host (.i_frame(frame), .i_power_off(poff), .i_cur(cur),
        .o_scl(scl), .o_cur_a(cur_a), .o_cur_b(cur_b));
    fld_mode_ctrl #(.SCL_LOW_CYC(200), .FLASH_STEP_CYC(20)) u_dut (
        .i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_strobe(stb),
        .i_torch(trc), .i_vin_below_low_v(vlo), .i_vin_below_run(vrun),
        .i_mode(mode), .i_out_on(on), .i_ext_torch(ext), .i_strobe_on(son),
        .i_strobe_type(sty), .i_vin_low_v_shutdown(lsd), .i_ind_pwm(pwm),
        .i_flash_timeout(tmo), .i_led_current(cur_a),
        .i_sink_current_setting_b(cur_b), .i_txmask_current(txc),
        .i_fault_read(frd), .o_sink_current_a(sa), .o_sink_current_b(sb),
        .o_current_actual(act), .o_current_min(cmin), .o_fault_uvlo(uv),
        .o_fault_timeout(tf), .o_fault_txmask(txf), .o_mode(md),
        .o_shutdown(sd), .o_reg_reset(rr), .o_ctrl_clear(cc));
    ////////////////////////////////////////////////
    // Clock, hang limit and pulse catchers
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        ccs |= (cc === 1'b1);
        rrs |= (rr === 1'b1);
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Wait for a flash, note its first current and its length
    task automatic meas();
        n = 0;
        len = 0;
        while (act === 8'h00 && n < 3000) begin
            tick(1);
            n++;
        end
        first = act;
        while (act !== 8'h00 && len < 3000) begin
            tick(1);
            len++;
        end
    endtask : meas
    task automatic fread();
        frd = 1;
        tick(1);
        frd = 0;
        tick(2);
    endtask : fread
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(12);
        rst = 0;
        tick(4);
        chk(8'(md), 8'(fld_pkg::FLD_STANDBY));
        mode = 2;
        on = 1;
        tick(4);
        chk(sa, 8'h25);
        chk(8'(md), 8'(fld_pkg::FLD_ASSIST));
        on = 0;
        tick(4);
        chk(sb, 8'h00);
        mode = 0;
        ext = 2;
        trc = 1;
        tick(6);
        chk(sb, 8'h25);
        trc = 0;
        tick(6);
        chk(sa, 8'h00);
        $display("test torch and assist done");
        ext = 0;
        mode = 1;
        on = 1;
        pwm = 3;
        cur = 8'hFF;
        tick(10);
        n = 0;
        repeat (800) begin
            tick(1);
            n += (sa !== 8'h00);
            last = (sa !== 8'h00) ? sa : last;
        end
        chk(8'(n), 8'hC8);
        chk(last, 8'h3F);
        $display("test indicator done");
        on = 0;
        cur = 8'hA5;
        tick(2);
        mode = 3;
        on = 1;
        meas();
        chk(first, 8'hA5);
        chk(8'(len), 8'h3C);
        tick(3);
        chk(cmin, 8'hA5);
        chk(tf, 1'b1);
        on = 0;
        tick(3);
        fread();
        chk(tf, 1'b0);
        $display("test timed flash done");
        son = 1;
        ext = 1;
        on = 1;
        tick(20);
        chk(act, 8'h00);
        trc = 1;
        stb = 1;
        meas();
        chk(first, 8'h40);
        chk(8'(len), 8'h3C);
        chk(txf, 1'b1);
        tick(100);
        chk(act, 8'h00);
        stb = 0;
        trc = 0;
        ext = 0;
        sty = 1;
        tmo = 9;
        tick(4);
        stb = 1;
        tick(50);
        chk(act, 8'hA5);
        tick(50);
        stb = 0;
        tick(10);
        chk(act, 8'h00);
        chk(tf, 1'b0);
        tmo = 2;
        stb = 1;
        tick(100);
        chk(tf, 1'b1);
        chk(sa, 8'h00);
        chk(ccs, 1'b1);
        stb = 0;
        on = 0;
        son = 0;
        $display("test strobe flash done");
        tick(3);
        fread();
        vlo = 1;
        lsd = 1;
        tick(3);
        on = 1;
        tick(10);
        chk(sa, 8'h00);
        chk(uv, 1'b1);
        on = 0;
        lsd = 0;
        tick(3);
        on = 1;
        meas();
        chk(first, 8'h40);
        on = 0;
        vlo = 0;
        tmo = 20;
        // Diagnostic flash against the stricter running threshold
        vrun = 1;
        tick(3);
        on = 1;
        meas();
        chk(first, 8'hA5);
        tick(3);
        chk(cmin, 8'hA3);
        chk(uv, 1'b1);
        on = 0;
        vrun = 0;
        cur = cmin;
        tick(3);
        fread();
        chk(uv, 1'b0);
        on = 1;
        meas();
        chk(first, 8'hA3);
        chk(uv, 1'b0);
        $display("test supply checks done");
        frame = 1;
        mode = 2;
        on = 1;
        tick(50);
        chk(sd, 1'b0);
        poff = 1;
        tick(220);
        chk(sd, 1'b1);
        chk(sa, 8'h00);
        chk(rrs, 1'b1);
        mode = 0;
        on = 0;
        poff = 0;
        frame = 0;
        tick(8);
        chk(sd, 1'b0);
        $display("test clock low shutdown done");
        close_out();
    end
endmodule : flash_led_mode_control_tb
